// file: pmt_device.sv
`timescale 1ns/100ps
// How it works
// - Answer own address and broadcast zero
// - Broadcast reads and writes are accepted
// - Strap or register bit disables broadcast
// - Unique address latched from straps at reset
// - Frame starts preamble, start, opcode
// - Address, turnaround, sixteen data bits
// - Decode four of thirty-two register addresses; others read zero
// - Interrupt only for enabled conditions
// - Record conditions in status bits
// - Reading status register clears it
// - Interrupt polarity chosen by control bit
// - Auto crossover on by default
// - Forced pair choice when auto off
// - Auto mode follows sensed partner pairs
// - Straight transmits 1-2, crossed swaps
// - Local loopback full duplex only
// - Local loopback via basic control bits
// - Remote loopback only 100 full
// - Remote loopback needs 100 full link
module pmt_device
	import pmt_pkg::*;
(
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Management link
	pmt_mgmt_if.device mgmt,
	// Straps
	input wire logic [2:0] phy_address_strap_i,
	input wire logic broadcast_disable_strap_i,
	// Events and line status
	input wire logic [7:0] int_event_i,
	input wire logic partner_crossed_i,
	input wire logic link_100_full_i,
	// Outputs
	output logic interrupt_request_out_o,
	output logic pair_crossed_o,
	output logic local_loop_o,
	output logic remote_loop_o
);
	typedef enum logic [2:0] {PMT_IDLE, PMT_PRE, PMT_HDR, PMT_TA, PMT_DATA} pmt_state_e;
	pmt_state_e state_q;
	logic [1:0] mdc_sync_q, mdio_sync_q;
	logic mdc_last_q;
	logic [5:0] cnt_q;
	logic [11:0] hdr_q;
	logic [15:0] sh_q;
	logic drive_q;
	logic [2:0] phy_addr_q;
	logic bcast_off_strap_q;
	logic strap_done_q;
	logic [3:0] strap_s1_q, strap_s2_q;
	logic [15:0] basic_q, strap_ovr_q, ctrl2_q;
	logic [7:0] int_en_q, int_stat_q;
	logic rise, bit_in, is_read, hit, rd_clear, wr_pulse;
	logic [4:0] reg_sel;

	// Two-stage capture of clock and data pins
	always_ff @(posedge clk_i) begin
		mdc_sync_q <= {mdc_sync_q[0], mgmt.mdc};
		mdio_sync_q <= {mdio_sync_q[0], mgmt.mdio};
		mdc_last_q <= mdc_sync_q[1];
	end
	assign rise = mdc_sync_q[1] & ~mdc_last_q;
	assign bit_in = mdio_sync_q[1];

	// Strap pins pass two flops like the clock and data pins
	always_ff @(posedge clk_i) begin
		strap_s1_q <= {broadcast_disable_strap_i, phy_address_strap_i};
		strap_s2_q <= strap_s1_q;
	end

	// Straps latched in the first clocked cycle after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			phy_addr_q <= strap_s2_q[2:0];
			bcast_off_strap_q <= strap_s2_q[3];
		end
	end

	// Frame fields: hdr = op(2) phy(5) reg(5)
	assign is_read = (hdr_q[11:10] == OP_READ);
	assign reg_sel = hdr_q[4:0];
	// Own address, or zero while broadcast is enabled
	assign hit = (hdr_q[9:8] == ADDR_HIGH) && ((hdr_q[7:5] == phy_addr_q)
		|| ((hdr_q[7:5] == BCAST_ADDR) && !bcast_off_strap_q
		&& !strap_ovr_q[BIT_BCAST_OFF]));

	// Register read mux
	function automatic logic [15:0] rd_mux(input logic [4:0] a);
		case (a)
			REG_BASIC_CTRL: rd_mux = basic_q;
			REG_STRAP_OVR: rd_mux = strap_ovr_q;
			REG_INT_EN_STAT: rd_mux = {int_en_q, int_stat_q};
			REG_CTRL_TWO: rd_mux = ctrl2_q;
			default: rd_mux = ZERO16;
		endcase
	endfunction

	// Frame sequencer, one step per rising management clock
	always_ff @(posedge clk_i) begin
		rd_clear <= 1'b0;
		wr_pulse <= 1'b0;
		if (rst_i) begin
			state_q <= PMT_IDLE;
			cnt_q <= 6'h00;
			drive_q <= 1'b0;
			hdr_q <= 12'h000;
			sh_q <= 16'h0000;
		end else if (rise) begin
			case (state_q)
				PMT_IDLE: begin
					drive_q <= 1'b0;
					// Count consecutive ones; saturate
					if (bit_in) begin
						if (cnt_q != 6'(PREAMBLE_ONES)) cnt_q <= cnt_q + 6'h01;
					end else if (cnt_q == 6'(PREAMBLE_ONES)) begin
						state_q <= PMT_PRE;
					end else begin
						cnt_q <= 6'h00;
					end
				end
				PMT_PRE: begin
					// Second start bit must be one
					cnt_q <= 6'h00;
					state_q <= bit_in ? PMT_HDR : PMT_IDLE;
				end
				PMT_HDR: begin
					hdr_q <= {hdr_q[10:0], bit_in};
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == 6'h0B) begin
						cnt_q <= 6'h00;
						state_q <= PMT_TA;
					end
				end
				PMT_TA: begin
					// Bad opcode aborts; first turnaround bit floats
					if (hdr_q[11:10] != OP_READ && hdr_q[11:10] != OP_WRITE) begin
						state_q <= PMT_IDLE;
						cnt_q <= 6'h00;
					end else if (cnt_q == 6'h00) begin
						cnt_q <= 6'h01;
						if (is_read && hit) begin
							drive_q <= 1'b1;
							// Top bit of the shifter gives the turnaround zero
							sh_q <= ZERO16;
						end
					end else begin
						cnt_q <= 6'h00;
						state_q <= PMT_DATA;
						if (is_read && hit) begin
							sh_q <= rd_mux(reg_sel);
							rd_clear <= (reg_sel == REG_INT_EN_STAT);
						end
					end
				end
				PMT_DATA: begin
					if (is_read) begin
						sh_q <= {sh_q[14:0], 1'b0};
					end else begin
						sh_q <= {sh_q[14:0], bit_in};
					end
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == 6'h0F) begin
						cnt_q <= 6'h00;
						drive_q <= 1'b0;
						state_q <= PMT_IDLE;
						wr_pulse <= !is_read && hit;
					end
				end
				default: state_q <= PMT_IDLE;
			endcase
		end
	end

	// Drive only in turnaround/data of a read to own or broadcast address
	assign mgmt.mdio_d_oe = drive_q;
	assign mgmt.mdio_d_o = sh_q[15];

	// Writable registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			basic_q <= BASIC_CTRL_RST;
			strap_ovr_q <= ZERO16;
			ctrl2_q <= ZERO16;
			int_en_q <= 8'h00;
		end else if (wr_pulse) begin
			case (reg_sel)
				REG_BASIC_CTRL: basic_q <= sh_q;
				REG_STRAP_OVR: strap_ovr_q <= sh_q;
				REG_INT_EN_STAT: int_en_q <= sh_q[15:INT_EN_LSB];
				REG_CTRL_TWO: ctrl2_q <= sh_q;
				default: ;
			endcase
		end
	end

	// Sticky status; a new event wins over the read clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_stat_q <= 8'h00;
		end else begin
			int_stat_q <= (rd_clear ? 8'h00 : int_stat_q) | int_event_i;
		end
	end

	// Mode outputs and interrupt pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			interrupt_request_out_o <= 1'b1;
			pair_crossed_o <= 1'b0;
			local_loop_o <= 1'b0;
			remote_loop_o <= 1'b0;
		end else begin
			interrupt_request_out_o <= ((|(int_stat_q & int_en_q))
				== ctrl2_q[BIT_INT_HIGH]);
			// Crossed means transmit on 3-6 instead of 1-2
			pair_crossed_o <= ctrl2_q[BIT_XOVER_OFF] ? ctrl2_q[BIT_XOVER_SEL]
				: partner_crossed_i;
			local_loop_o <= basic_q[BIT_LOCAL_LOOP] && basic_q[BIT_FULL_DUPLEX]
				&& !basic_q[BIT_AUTONEG];
			// Forced and negotiated links both report through link_100_full_i
			remote_loop_o <= ctrl2_q[BIT_REMOTE_LOOP] && link_100_full_i;
		end
	end
endmodule // pmt_device

// file: pmt_pkg.sv
package pmt_pkg;
	// Register indices on the management bus
	localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
	localparam logic [4:0] REG_STRAP_OVR = 5'h16;
	localparam logic [4:0] REG_INT_EN_STAT = 5'h1B;
	localparam logic [4:0] REG_CTRL_TWO = 5'h1F;
	// Bit positions
	localparam int BIT_LOCAL_LOOP = 14;
	localparam int BIT_SPEED_100 = 13;
	localparam int BIT_AUTONEG = 12;
	localparam int BIT_FULL_DUPLEX = 8;
	localparam int BIT_BCAST_OFF = 9;
	localparam int BIT_INT_HIGH = 9;
	localparam int BIT_XOVER_OFF = 13;
	localparam int BIT_XOVER_SEL = 14;
	localparam int BIT_REMOTE_LOOP = 2;
	localparam int INT_EN_LSB = 8;
	// Reset values
	localparam logic [15:0] BASIC_CTRL_RST = 16'h3100;
	localparam logic [15:0] ZERO16 = 16'h0000;
	// Frame shape
	localparam int PREAMBLE_ONES = 32;
	localparam logic [1:0] SOF_CODE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] TA_WRITE = 2'h2;
	localparam logic [1:0] ADDR_HIGH = 2'h0;
	localparam logic [2:0] BCAST_ADDR = 3'h0;
	// Host command/status register indices (word addresses on Wishbone)
	localparam logic [1:0] WB_CMD = 2'h0;
	localparam logic [1:0] WB_WDATA = 2'h1;
	localparam logic [1:0] WB_STATUS = 2'h2;
	// Host divider: half period of management clock in system cycles
	localparam int MDC_HALF = 8;
endpackage

// file: pmt_mgmt_if.sv
`timescale 1ns/100ps
interface pmt_mgmt_if;
	// Management clock, driven by the master
	logic mdc;
	// Data line, three signals per end
	logic mdio_m_o;
	logic mdio_m_oe;
	logic mdio_d_o;
	logic mdio_d_oe;
	logic mdio;
	// Pulled up when nobody drives
	assign mdio = mdio_m_oe ? mdio_m_o : (mdio_d_oe ? mdio_d_o : 1'b1);
	modport device (input mdc, input mdio, output mdio_d_o, output mdio_d_oe);
	modport master (output mdc, input mdio, output mdio_m_o, output mdio_m_oe);
endinterface

// file: pmt_master.sv
`timescale 1ns/100ps
module pmt_master
	import pmt_pkg::*;
(
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Management link
	pmt_mgmt_if.master mgmt
);
	typedef enum logic [1:0] {PMM_IDLE, PMM_SHIFT, PMM_READ} pmm_state_e;
	pmm_state_e state_q;
	logic [63:0] frame_q;
	logic [6:0] bits_q;
	logic [15:0] wdata_q, rdata_q;
	logic [4:0] div_q;
	logic mdc_q, oe_q, busy_q, is_rd_q, go_q;
	logic [2:0] cmd_phy_q;
	logic [4:0] cmd_reg_q;
	logic [1:0] sync_q;
	logic [1:0] idx;
	assign idx = adr_i[3:2];

	// Wishbone decode; ack one cycle, dropped next
	always_ff @(posedge clk_i) begin
		go_q <= 1'b0;
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
			wdata_q <= 16'h0000;
			cmd_phy_q <= 3'h0;
			cmd_reg_q <= 5'h00;
			is_rd_q <= 1'b0;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
			if (cyc_i && stb_i && !ack_o) begin
				dat_o <= 32'h0000_0000;
				if (!we_i && idx == WB_STATUS) dat_o <= {15'h0000, busy_q, rdata_q};
				if (!we_i && idx == WB_WDATA) dat_o <= {16'h0000, wdata_q};
			end
			// Writes land only on the edge at which the master sees ack high
			if (cyc_i && stb_i && we_i && sel_i[0] && ack_o) begin
				if (idx == WB_WDATA) wdata_q <= dat_i[15:0];
				if (idx == WB_CMD && !busy_q) begin
					// cmd: [4:0] reg, [7:5] phy, [8] read
					cmd_reg_q <= dat_i[4:0];
					cmd_phy_q <= dat_i[7:5];
					is_rd_q <= dat_i[8];
					go_q <= 1'b1;
				end
			end
		end
	end

	// Pin capture
	always_ff @(posedge clk_i) sync_q <= {sync_q[0], mgmt.mdio};

	// Frame shifter; bits change after falling edge, partner samples rising
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= PMM_IDLE;
			busy_q <= 1'b0;
			mdc_q <= 1'b0;
			oe_q <= 1'b0;
			div_q <= 5'h00;
			bits_q <= 7'h00;
			frame_q <= 64'h0;
			rdata_q <= 16'h0000;
		end else begin
			case (state_q)
				PMM_IDLE: begin
					mdc_q <= 1'b0;
					if (go_q) begin
						busy_q <= 1'b1;
						state_q <= PMM_SHIFT;
						oe_q <= 1'b1;
						bits_q <= 7'h40;
						div_q <= 5'h00;
						frame_q <= {32'hFFFF_FFFF, SOF_CODE, is_rd_q ? OP_READ : OP_WRITE,
							ADDR_HIGH, cmd_phy_q, cmd_reg_q, TA_WRITE, wdata_q};
					end
				end
				PMM_SHIFT: begin
					div_q <= div_q + 5'h01;
					if (div_q == 5'(MDC_HALF - 1)) begin
						div_q <= 5'h00;
						mdc_q <= ~mdc_q;
						if (mdc_q) begin
							// Falling edge: advance one bit
							frame_q <= {frame_q[62:0], 1'b0};
							bits_q <= bits_q - 7'h01;
							if (is_rd_q && bits_q == 7'h13) oe_q <= 1'b0;
							if (bits_q == 7'h01) begin
								oe_q <= 1'b0;
								state_q <= PMM_IDLE;
								busy_q <= 1'b0;
							end
						end else if (is_rd_q && bits_q <= 7'h10) begin
							rdata_q <= {rdata_q[14:0], sync_q[1]};
						end
					end
				end
				default: state_q <= PMM_IDLE;
			endcase
		end
	end

	assign mgmt.mdc = mdc_q;
	assign mgmt.mdio_m_o = frame_q[63];
	assign mgmt.mdio_m_oe = oe_q;
endmodule // pmt_master

// file: pmt_mgmt_monitor.sv
`timescale 1ns/100ps
module pmt_mgmt_monitor (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Link wires
	input wire logic mdc,
	input wire logic mdio,
	input wire logic mdio_m_o,
	input wire logic mdio_m_oe,
	input wire logic mdio_d_o,
	input wire logic mdio_d_oe
);
	logic mdc_q;
	logic pre_q;
	logic [5:0] ones_q;
	logic [8:0] drv_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Previous link clock, for rise detection
	always_ff @(posedge clk_i) begin
		mdc_q <= mdc;
	end
	// Ones seen before the first zero of a frame
	always_ff @(posedge clk_i) begin
		if (rst_i || !mdio_m_oe) begin
			pre_q <= 1'b1;
			ones_q <= 6'h00;
		end else if (mdc && !mdc_q) begin
			pre_q <= pre_q && mdio;
			ones_q <= (pre_q && mdio) ? ones_q + 6'h01 : ones_q;
		end
	end
	// Device drive length; checked only when the driver lets go
	always_ff @(posedge clk_i) begin
		if (rst_i || !mdio_d_oe) begin
			drv_q <= 9'h000;
		end else begin
			drv_q <= drv_q + 9'h001;
		end
	end
	sequence s_rise;
		mdc && !mdc_q;
	endsequence
	sequence s_high_half;
		mdc [*8] ##1 !mdc;
	endsequence
	a_one_driver: assert property (!(mdio_m_oe && mdio_d_oe))
		else $error("both ends drive the data line");
	a_reset_idle: assert property ($fell(rst_i) |-> !mdc && !mdio_m_oe && !mdio_d_oe)
		else $error("link not idle after reset");
	a_clock_half: assert property ($rose(mdc) |-> s_high_half)
		else $error("link clock high phase wrong");
	a_ta_zero: assert property ($rose(mdio_d_oe) |-> !mdio_d_o)
		else $error("turnaround bit not zero");
	a_drive_span: assert property ($fell(mdio_d_oe) |-> drv_q >= 9'h0F0 && drv_q <= 9'h122)
		else $error("device drive length wrong");
	a_master_steady: assert property (mdio_m_oe && $changed(mdio_m_o) |-> !mdc)
		else $error("master data moved while clock high");
	// Device moves its data a few cycles after a rise, well clear of the next one
	a_dev_steady: assert property (mdio_d_oe && $past(mdio_d_oe) && $changed(mdio_d_o) |-> mdc)
		else $error("device data moved while clock low");
	a_preamble_run: assert property (s_rise ##0 (mdio_m_oe && pre_q && !mdio) |-> ones_q == 6'h20)
		else $error("preamble length wrong");
endmodule // pmt_mgmt_monitor

// file: phy_management_and_test_control_test.sv
`timescale 1ns/100ps
module phy_management_and_test_control_test
	import pmt_pkg::*;
();
	logic clk_i;
	logic rst_i;
	logic cyc, stb, we, bdis, pc, l100, ack, irq, xo, ll, rl;
	logic [3:0] adr;
	logic [31:0] dat, rdat, got;
	logic [2:0] strap;
	logic [7:0] ev;
	logic [15:0] r;
	int num_errors;
	int comparisons;
	pmt_mgmt_if mgmt_bus ();
	// Read flag, address, register, data or expected read, {irq, xover, local, remote}
	logic [28:0] rows [14] = '{
		{1'b1, 3'h5, 5'h00, 16'h3100, 4'hC},
		{1'b0, 3'h5, 5'h1F, 16'h2000, 4'h8},
		{1'b0, 3'h5, 5'h1F, 16'h6000, 4'hC},
		{1'b0, 3'h0, 5'h1F, 16'h2004, 4'h9},
		{1'b1, 3'h0, 5'h1F, 16'h2004, 4'h9},
		{1'b0, 3'h5, 5'h00, 16'h4100, 4'hB},
		{1'b0, 3'h5, 5'h00, 16'h5100, 4'h9},
		{1'b0, 3'h5, 5'h00, 16'h6000, 4'h9},
		{1'b0, 3'h3, 5'h00, 16'h4100, 4'h9},
		{1'b1, 3'h5, 5'h00, 16'h6000, 4'h9},
		{1'b0, 3'h5, 5'h1F, 16'h0000, 4'hC},
		{1'b0, 3'h5, 5'h16, 16'h0200, 4'hC},
		{1'b1, 3'h0, 5'h00, 16'hFFFF, 4'hC},
		{1'b1, 3'h5, 5'h16, 16'h0200, 4'hC}
	};
	pmt_device u_pmt_device (.clk_i(clk_i), .rst_i(rst_i), .mgmt(mgmt_bus.device),
		.phy_address_strap_i(strap), .broadcast_disable_strap_i(bdis), .int_event_i(ev),
		.partner_crossed_i(pc), .link_100_full_i(l100), .interrupt_request_out_o(irq),
		.pair_crossed_o(xo), .local_loop_o(ll), .remote_loop_o(rl));
	pmt_master u_pmt_master (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .mgmt(mgmt_bus.master));
	pmt_mgmt_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .mdc(mgmt_bus.mdc), .mdio(mgmt_bus.mdio),
		.mdio_m_o(mgmt_bus.mdio_m_o), .mdio_m_oe(mgmt_bus.mdio_m_oe),
		.mdio_d_o(mgmt_bus.mdio_d_o), .mdio_d_oe(mgmt_bus.mdio_d_oe));
	// Free-running system clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (num_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// One bus cycle; request held until ack is sampled
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		got = rdat;
		if (n >= 50) begin
			num_errors++;
			wrap_up();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	// Full management transfer, then poll until idle
	task automatic mio(input logic rd, input logic [2:0] p, input logic [4:0] g,
		input logic [15:0] d);
		int n;
		n = 0;
		wb(1'b1, 4'h4, {16'h0000, d});
		wb(1'b1, 4'h0, {23'h000000, rd, p, g});
		do begin
			wb(1'b0, 4'h8, 32'h00000000);
			n++;
		end while (got[16] !== 1'b0 && n < 500);
		if (n >= 500) begin
			num_errors++;
			wrap_up();
		end
		r = got[15:0];
	endtask
	// Main sequence
	initial begin
		num_errors = 0;
		comparisons = 0;
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		dat = 32'h00000000;
		strap = 3'h5;
		bdis = 1'b0;
		ev = 8'h00;
		pc = 1'b1;
		l100 = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		for (int i = 0; i < 14; i++) begin
			mio(rows[i][28], rows[i][27:25], rows[i][24:20], rows[i][19:4]);
			repeat (8) @(posedge clk_i);
			if (rows[i][28]) check(r, rows[i][19:4]);
			check({12'h000, irq, xo, ll, rl}, {12'h000, rows[i][3:0]});
		end
		// Events only reach the pin when enabled; status always records
		mio(1'b0, 3'h5, 5'h1B, 16'h0200);
		ev <= 8'h01;
		@(posedge clk_i);
		ev <= 8'h00;
		repeat (4) @(posedge clk_i);
		check({15'h0000, irq}, 16'h0001);
		mio(1'b1, 3'h5, 5'h1B, 16'h0000);
		check(r, 16'h0201);
		mio(1'b1, 3'h5, 5'h1B, 16'h0000);
		check(r, 16'h0200);
		ev <= 8'h02;
		@(posedge clk_i);
		ev <= 8'h00;
		repeat (4) @(posedge clk_i);
		check({15'h0000, irq}, 16'h0000);
		mio(1'b0, 3'h5, 5'h1F, 16'h0200);
		repeat (8) @(posedge clk_i);
		check({15'h0000, irq}, 16'h0001);
		mio(1'b1, 3'h5, 5'h1B, 16'h0000);
		check(r, 16'h0202);
		repeat (4) @(posedge clk_i);
		check({15'h0000, irq}, 16'h0000);
		pc <= 1'b0;
		repeat (4) @(posedge clk_i);
		check({15'h0000, xo}, 16'h0000);
		l100 <= 1'b0;
		mio(1'b0, 3'h5, 5'h1F, 16'h0004);
		repeat (8) @(posedge clk_i);
		check({15'h0000, rl}, 16'h0000);
		l100 <= 1'b1;
		repeat (4) @(posedge clk_i);
		check({15'h0000, rl}, 16'h0001);
		wb(1'b0, 4'hC, 32'h00000000);
		// Second reset with broadcast strapped off and a new address
		bdis <= 1'b1;
		strap <= 3'h2;
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		strap <= 3'h6;
		check({12'h000, irq, xo, ll, rl}, 16'h0008);
		mio(1'b1, 3'h0, 5'h00, 16'h0000);
		check(r, 16'hFFFF);
		mio(1'b1, 3'h2, 5'h00, 16'h0000);
		check(r, 16'h3100);
		wrap_up();
	end
endmodule // phy_management_and_test_control_test
